// [core/cabx_defs.vh]
`ifndef CABX_DEFS_VH
`define CABX_DEFS_VH
// ---------------------------------------------------------------
// operation codes
// ---------------------------------------------------------------
`define CABX_OP_ADD     6'h00
`define CABX_OP_ADDC    6'h01
`define CABX_OP_SUB     6'h02
`define CABX_OP_SUBC    6'h03
`define CABX_OP_SUB_IMM    6'h04
`define CABX_OP_SUBCI   6'h05
`define CABX_OP_AND     6'h06
`define CABX_OP_AND_IMM    6'h07
`define CABX_OP_OR      6'h08
`define CABX_OP_ORI     6'h09
`define CABX_OP_EOR     6'h0A
`define CABX_OP_COM     6'h0B
`define CABX_OP_NEG     6'h0C
`define CABX_OP_SETB    6'h0D
`define CABX_OP_CLRB    6'h0E
`define CABX_OP_INC     6'h0F
`define CABX_OP_DEC     6'h10
`define CABX_OP_TST     6'h11
`define CABX_OP_CLR     6'h12
`define CABX_OP_SER     6'h13
`define CABX_OP_CP      6'h14
`define CABX_OP_CPC     6'h15
`define CABX_OP_CPI     6'h16
`define CABX_OP_CSEQ    6'h17
`define CABX_OP_SKRC    6'h18
`define CABX_OP_SKRS    6'h19
`define CABX_OP_SKIC    6'h1A
`define CABX_OP_SKIS    6'h1B
`define CABX_OP_BRFS    6'h1C
`define CABX_OP_BRFC    6'h1D
`define CABX_OP_BRANCH_SIGNED_GE    6'h1E
`define CABX_OP_BRANCH_SIGNED_LT    6'h1F
`define CABX_OP_BRUGE   6'h20
`define CABX_OP_BRULO   6'h21
`define CABX_OP_BRANCH_HALF_SET    6'h22
`define CABX_OP_BRANCH_HALF_CLR    6'h23
`define CABX_OP_BRANCH_TBIT_SET    6'h24
`define CABX_OP_BRANCH_TBIT_CLR    6'h25
`define CABX_OP_BRANCH_OVF_SET    6'h26
`define CABX_OP_BRANCH_OVF_CLR    6'h27
`define CABX_OP_BRANCH_IRQ_ON    6'h28
`define CABX_OP_BRID    6'h29
`define CABX_OP_REL_JUMP    6'h2A
`define CABX_OP_REL_CALL   6'h2B
`define CABX_OP_RET     6'h2C
`define CABX_OP_IRQ_EXIT    6'h2D
// ---------------------------------------------------------------
// status word bit positions and reset values
// ---------------------------------------------------------------
`define CABX_SW_C       0
`define CABX_SW_Z       1
`define CABX_SW_N       2
`define CABX_SW_V       3
`define CABX_SW_S       4
`define CABX_SW_H       5
`define CABX_SW_T       6
`define CABX_SW_I       7
`define CABX_SW_RST     8'h00
`define CABX_RF_RST     8'h00
`define CABX_ALL_ONES   8'hFF
// ---------------------------------------------------------------
// cycle counts
// ---------------------------------------------------------------
`define CABX_CYC_ONE    2'h1
`define CABX_CYC_TAKEN  2'h2
`define CABX_CYC_JUMP   2'h2
`define CABX_CYC_CALL   2'h3
`define CABX_CYC_RET    3'h4
`endif

// [core/cabx_exec.v]
`timescale 1ns/10ps
`include "cabx_defs.vh"
module cabx_exec #(
   parameter PC_W = 12,
   parameter SP_W = 3
) (
   // clock and reset
   input  wire            clk,
   input  wire            rst_n,
   // instruction stream
   input  wire            instr_valid,
   input  wire [5:0]      instr_op,
   input  wire [4:0]      instr_rd,
   input  wire [4:0]      instr_rr,
   input  wire [7:0]      instr_imm,
   input  wire [2:0]      instr_bit,
   input  wire [PC_W-1:0] instr_ofs,
   input  wire            instr_next_long,
   output wire            instr_ready,
   // addressed io register value
   input  wire [7:0]      io_value,
   // register file side port
   input  wire            rf_wr_en,
   input  wire [4:0]      rf_wr_addr,
   input  wire [7:0]      rf_wr_data,
   input  wire [4:0]      rf_rd_addr,
   output reg  [7:0]      rf_rd_data,
   // status word load
   input  wire            sw_wr_en,
   input  wire [7:0]      sw_wr_data,
   // core state
   output wire [PC_W-1:0] pc_out,
   output wire [7:0]      status_word_out
);

// ---------------------------------------------------------------
// state
// ---------------------------------------------------------------
localparam CL_NONE = 3'h0;
localparam CL_ADD  = 3'h1;
localparam CL_SUB  = 3'h2;
localparam CL_LOG  = 3'h3;
localparam CL_INC  = 3'h4;
localparam CL_DEC  = 3'h5;
localparam CL_COM  = 3'h6;

reg  [7:0]      rf [0:31];
reg  [PC_W-1:0] stk [0:(1<<SP_W)-1];
reg  [SP_W-1:0] sp_reg;
reg  [SP_W-1:0] sp_next;
reg  [PC_W-1:0] pc_reg;
reg  [PC_W-1:0] pc_next;
reg  [7:0]      sw_reg;
reg  [7:0]      sw_next;
reg  [1:0]      wait_reg;
reg  [1:0]      wait_next;

reg  [7:0]      x_opd;
reg  [7:0]      y_opd;
reg             cin;
reg  [2:0]      cls;
reg             store;
reg  [7:0]      lres;
reg  [7:0]      res;
reg  [8:0]      sum9;
reg  [8:0]      diff9;
reg             take;
reg             is_flow;
reg             push;
reg             pop;
reg  [2:0]      cyc;
reg  [2:0]      bidx;
reg             bwant;
reg             use_bit;
reg  [PC_W-1:0] skip_step;

wire            fire = instr_valid & instr_ready;
wire [7:0]      rd_val = rf[instr_rd];
wire [7:0]      rr_val = rf[instr_rr];
wire            carry = sw_reg[`CABX_SW_C];
integer         i;

assign instr_ready     = (wait_reg == 2'h0);
assign pc_out          = pc_reg;
assign status_word_out = sw_reg;

// ---------------------------------------------------------------
// flag helpers
// ---------------------------------------------------------------
function add_half;
   input [7:0] a;
   input [7:0] b;
   input [7:0] r;
   begin
      add_half = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
   end
endfunction

function add_ovf;
   input [7:0] a;
   input [7:0] b;
   input [7:0] r;
   begin
      add_ovf = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
   end
endfunction

function sub_half;
   input [7:0] a;
   input [7:0] b;
   input [7:0] r;
   begin
      sub_half = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
   end
endfunction

function sub_ovf;
   input [7:0] a;
   input [7:0] b;
   input [7:0] r;
   begin
      sub_ovf = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
   end
endfunction

// ---------------------------------------------------------------
// decode
// ---------------------------------------------------------------
always @* begin
   x_opd   = rd_val;
   y_opd   = rr_val;
   cin     = 1'b0;
   cls     = CL_NONE;
   store   = 1'b0;
   lres    = 8'h00;
   is_flow = 1'b0;
   use_bit = 1'b0;
   bidx    = instr_bit;
   bwant   = 1'b1;
   take    = 1'b0;
   push    = 1'b0;
   pop     = 1'b0;
   cyc     = {1'b0, `CABX_CYC_ONE};
   case (instr_op)
      `CABX_OP_ADD, `CABX_OP_ADDC: begin
         cls   = CL_ADD;
         store = 1'b1;
         cin   = (instr_op == `CABX_OP_ADDC) & carry;
      end
      `CABX_OP_SUB, `CABX_OP_SUBC: begin
         cls   = CL_SUB;
         store = 1'b1;
         cin   = (instr_op == `CABX_OP_SUBC) & carry;
      end
      `CABX_OP_SUB_IMM, `CABX_OP_SUBCI: begin
         cls   = CL_SUB;
         store = 1'b1;
         y_opd = instr_imm;
         cin   = (instr_op == `CABX_OP_SUBCI) & carry;
      end
      `CABX_OP_CP, `CABX_OP_CPC: begin
         cls = CL_SUB;
         cin = (instr_op == `CABX_OP_CPC) & carry;
      end
      `CABX_OP_CPI: begin
         cls   = CL_SUB;
         y_opd = instr_imm;
      end
      `CABX_OP_AND: begin
         cls   = CL_LOG;
         store = 1'b1;
         lres  = rd_val & rr_val;
      end
      `CABX_OP_AND_IMM: begin
         cls   = CL_LOG;
         store = 1'b1;
         lres  = rd_val & instr_imm;
      end
      `CABX_OP_OR: begin
         cls   = CL_LOG;
         store = 1'b1;
         lres  = rd_val | rr_val;
      end
      `CABX_OP_ORI, `CABX_OP_SETB: begin
         cls   = CL_LOG;
         store = 1'b1;
         lres  = rd_val | instr_imm;
      end
      `CABX_OP_CLRB: begin
         cls   = CL_LOG;
         store = 1'b1;
         lres  = rd_val & (`CABX_ALL_ONES - instr_imm);
      end
      `CABX_OP_TST: begin
         cls  = CL_LOG;
         lres = rd_val & rd_val;
      end
      `CABX_OP_EOR: begin
         cls   = CL_LOG;
         store = 1'b1;
         lres  = rd_val ^ rr_val;
      end
      `CABX_OP_CLR: begin
         cls   = CL_LOG;
         store = 1'b1;
         lres  = rd_val ^ rd_val;
      end
      `CABX_OP_SER: begin
         store = 1'b1;
         lres  = `CABX_ALL_ONES;
      end
      `CABX_OP_COM: begin
         cls   = CL_COM;
         store = 1'b1;
         lres  = `CABX_ALL_ONES - rd_val;
      end
      `CABX_OP_NEG: begin
         cls   = CL_SUB;
         store = 1'b1;
         x_opd = 8'h00;
         y_opd = rd_val;
      end
      `CABX_OP_INC: begin
         cls   = CL_INC;
         store = 1'b1;
         y_opd = 8'h01;
      end
      `CABX_OP_DEC: begin
         cls   = CL_DEC;
         store = 1'b1;
         y_opd = 8'h01;
      end
      `CABX_OP_CSEQ: begin
         is_flow = 1'b1;
         take    = (rd_val == rr_val);
      end
      `CABX_OP_SKRC, `CABX_OP_SKRS: begin
         is_flow = 1'b1;
         take    = (rr_val[instr_bit] == (instr_op == `CABX_OP_SKRS));
      end
      `CABX_OP_SKIC, `CABX_OP_SKIS: begin
         is_flow = 1'b1;
         take    = (io_value[instr_bit] == (instr_op == `CABX_OP_SKIS));
      end
      `CABX_OP_BRFS, `CABX_OP_BRFC: begin
         use_bit = 1'b1;
         bwant   = (instr_op == `CABX_OP_BRFS);
      end
      `CABX_OP_BRANCH_SIGNED_GE: begin
         is_flow = 1'b1;
         take    = ~(sw_reg[`CABX_SW_N] ^ sw_reg[`CABX_SW_V]);
      end
      `CABX_OP_BRANCH_SIGNED_LT: begin
         is_flow = 1'b1;
         take    = sw_reg[`CABX_SW_N] ^ sw_reg[`CABX_SW_V];
      end
      `CABX_OP_BRUGE, `CABX_OP_BRULO: begin
         use_bit = 1'b1;
         bidx    = `CABX_SW_C;
         bwant   = (instr_op == `CABX_OP_BRULO);
      end
      `CABX_OP_BRANCH_HALF_SET, `CABX_OP_BRANCH_HALF_CLR: begin
         use_bit = 1'b1;
         bidx    = `CABX_SW_H;
         bwant   = (instr_op == `CABX_OP_BRANCH_HALF_SET);
      end
      `CABX_OP_BRANCH_TBIT_SET, `CABX_OP_BRANCH_TBIT_CLR: begin
         use_bit = 1'b1;
         bidx    = `CABX_SW_T;
         bwant   = (instr_op == `CABX_OP_BRANCH_TBIT_SET);
      end
      `CABX_OP_BRANCH_OVF_SET, `CABX_OP_BRANCH_OVF_CLR: begin
         use_bit = 1'b1;
         bidx    = `CABX_SW_V;
         bwant   = (instr_op == `CABX_OP_BRANCH_OVF_SET);
      end
      `CABX_OP_BRANCH_IRQ_ON, `CABX_OP_BRID: begin
         use_bit = 1'b1;
         bidx    = `CABX_SW_I;
         bwant   = (instr_op == `CABX_OP_BRANCH_IRQ_ON);
      end
      `CABX_OP_REL_JUMP: begin
         is_flow = 1'b1;
         take    = 1'b1;
         cyc     = {1'b0, `CABX_CYC_JUMP};
      end
      `CABX_OP_REL_CALL: begin
         is_flow = 1'b1;
         take    = 1'b1;
         push    = 1'b1;
         cyc     = {1'b0, `CABX_CYC_CALL};
      end
      `CABX_OP_RET, `CABX_OP_IRQ_EXIT: begin
         is_flow = 1'b1;
         take    = 1'b1;
         pop     = 1'b1;
         cyc     = `CABX_CYC_RET;
      end
      default: begin
         cls = CL_NONE;
      end
   endcase
   if (use_bit) begin
      is_flow = 1'b1;
      take    = (sw_reg[bidx] == bwant);
   end
   // a taken skip or branch costs one extra cycle, untaken costs none
   if (is_flow & take & ~push & ~pop & (instr_op != `CABX_OP_REL_JUMP)) begin
      cyc = {1'b0, `CABX_CYC_TAKEN};
   end
end

// ---------------------------------------------------------------
// result, flags and next program counter
// ---------------------------------------------------------------
always @* begin
   sum9    = {1'b0, x_opd} + {1'b0, y_opd} + {8'h00, cin};
   diff9   = {1'b0, x_opd} - {1'b0, y_opd} - {8'h00, cin};
   res     = lres;
   sw_next = sw_reg;
   case (cls)
      CL_ADD, CL_INC: begin
         res                 = sum9[7:0];
         sw_next[`CABX_SW_V] = add_ovf(x_opd, y_opd, res);
      end
      CL_SUB, CL_DEC: begin
         res                 = diff9[7:0];
         sw_next[`CABX_SW_V] = sub_ovf(x_opd, y_opd, res);
      end
      default: begin
         sw_next[`CABX_SW_V] = 1'b0;
      end
   endcase
   if (cls == CL_ADD) begin
      sw_next[`CABX_SW_C] = sum9[8];
      sw_next[`CABX_SW_H] = add_half(x_opd, y_opd, res);
   end
   if (cls == CL_SUB) begin
      sw_next[`CABX_SW_C] = diff9[8];
      sw_next[`CABX_SW_H] = sub_half(x_opd, y_opd, res);
   end
   if (cls == CL_COM) begin
      sw_next[`CABX_SW_C] = 1'b1;
   end
   if (cls != CL_NONE) begin
      sw_next[`CABX_SW_Z] = (res == 8'h00);
      sw_next[`CABX_SW_N] = res[7];
      sw_next[`CABX_SW_S] = res[7] ^ sw_next[`CABX_SW_V];
   end else begin
      // flow control and ser leave every flag alone here; irq exit then sets I below
      sw_next = sw_reg;
   end
   if (pop & (instr_op == `CABX_OP_IRQ_EXIT)) begin
      sw_next[`CABX_SW_I] = 1'b1;
   end
   skip_step = instr_next_long ? {{(PC_W-2){1'b0}}, 2'h3} : {{(PC_W-2){1'b0}}, 2'h2};
   sp_next   = sp_reg;
   pc_next   = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
   if (is_flow & take) begin
      case (instr_op)
         `CABX_OP_CSEQ, `CABX_OP_SKRC, `CABX_OP_SKRS,
         `CABX_OP_SKIC, `CABX_OP_SKIS: begin
            pc_next = pc_reg + skip_step;
         end
         `CABX_OP_RET, `CABX_OP_IRQ_EXIT: begin
            sp_next = sp_reg - {{(SP_W-1){1'b0}}, 1'b1};
            pc_next = stk[sp_next];
         end
         default: begin
            pc_next = pc_reg + instr_ofs + {{(PC_W-1){1'b0}}, 1'b1};
         end
      endcase
      if (push) begin
         sp_next = sp_reg + {{(SP_W-1){1'b0}}, 1'b1};
      end
   end
   wait_next = wait_reg - 2'h1;
   if (fire) begin
      wait_next = cyc[1:0] - 2'h1;
      if (cyc == `CABX_CYC_RET) begin
         wait_next = 2'h3;
      end
   end else if (wait_reg == 2'h0) begin
      wait_next = 2'h0;
   end
end

// ---------------------------------------------------------------
// registers
// ---------------------------------------------------------------
always @(posedge clk or negedge rst_n) begin
   if (!rst_n) begin
      pc_reg     <= {PC_W{1'b0}};
      sw_reg     <= `CABX_SW_RST;
      sp_reg     <= {SP_W{1'b0}};
      wait_reg   <= 2'h0;
      rf_rd_data <= `CABX_RF_RST;
   end else begin
      wait_reg   <= wait_next;
      rf_rd_data <= rf[rf_rd_addr];
      if (fire) begin
         pc_reg <= pc_next;
         sp_reg <= sp_next;
         sw_reg <= sw_next;
      end else if (sw_wr_en) begin
         sw_reg <= sw_wr_data;
      end
   end
end

// register file and return stack carry no reset, as in a real core
always @(posedge clk) begin
   if (fire & store) begin
      rf[instr_rd] <= res;
   end
   if (rf_wr_en & ~(fire & store & (rf_wr_addr == instr_rd))) begin
      rf[rf_wr_addr] <= rf_wr_data;
   end
   if (fire & push) begin
      stk[sp_reg] <= pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
   end
end

endmodule // cabx_exec

// [verif/cabx_exec_props.sv]
`timescale 1ns/10ps
`include "cabx_defs.vh"
module cabx_exec_props #(
   parameter PC_W = 12,
   parameter SP_W = 3
) (
   // clock and reset
   input wire            clk,
   input wire            rst_n,
   // instruction stream
   input wire            instr_valid,
   input wire [5:0]      instr_op,
   input wire [2:0]      instr_bit,
   input wire [PC_W-1:0] instr_ofs,
   input wire            instr_next_long,
   input wire            instr_ready,
   input wire [7:0]      io_value,
   // core state
   input wire [PC_W-1:0] pc_out,
   input wire [7:0]      status_word_out
);
   // targets worked out at full pc width so wrap matches the core
   wire            acc   = instr_valid & instr_ready;
   wire [7:0]      sw    = status_word_out;
   wire [PC_W-1:0] pc_nx = pc_out + 1'h1;
   wire [PC_W-1:0] pc_tg = pc_out + instr_ofs + 1'h1;
   wire [PC_W-1:0] pc_sk = pc_out + (instr_next_long ? 2'h3 : 2'h2);

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   arith_sign_a: assert property (
      acc && instr_op inside {`CABX_OP_ADD, `CABX_OP_ADDC, `CABX_OP_SUB, `CABX_OP_SUBC,
      `CABX_OP_SUB_IMM, `CABX_OP_SUBCI, `CABX_OP_CPI} |=> sw[4] == (sw[2] ^ sw[3]))
      else $error("sign flag wrong after arithmetic");
   logic_keep_a: assert property (
      acc && instr_op inside {`CABX_OP_AND, `CABX_OP_AND_IMM, `CABX_OP_OR, `CABX_OP_ORI,
      `CABX_OP_SETB, `CABX_OP_CLRB, `CABX_OP_TST}
      |=> sw[0] == $past(sw[0]) && sw[5] == $past(sw[5]) && !sw[3] && sw[4] == sw[2])
      else $error("logic op disturbed carry, half or overflow");
   skip_flags_a: assert property (
      acc && instr_op >= `CABX_OP_CSEQ && instr_op <= `CABX_OP_SKIS |=> $stable(sw))
      else $error("skip changed status word");
   io_skip_a: assert property (
      acc && (instr_op == `CABX_OP_SKIC && !io_value[instr_bit]
      || instr_op == `CABX_OP_SKIS && io_value[instr_bit])
      |=> pc_out == $past(pc_sk) && !instr_ready ##1 instr_ready)
      else $error("io bit skip wrong");
   branch_flags_a: assert property (
      acc && instr_op >= `CABX_OP_BRFS && instr_op <= `CABX_OP_BRID |=> $stable(sw))
      else $error("branch changed status word");
   signed_ge_a: assert property (
      acc && instr_op == `CABX_OP_BRANCH_SIGNED_GE && !(sw[2] ^ sw[3])
      |=> pc_out == $past(pc_tg) && !instr_ready ##1 instr_ready)
      else $error("signed ge branch wrong");
   signed_lt_a: assert property (
      acc && instr_op == `CABX_OP_BRANCH_SIGNED_LT
      |=> pc_out == ($past(sw[2] ^ sw[3]) ? $past(pc_tg) : $past(pc_nx)))
      else $error("signed lt branch wrong");
   unsigned_br_a: assert property (
      acc && instr_op == `CABX_OP_BRULO
      |=> pc_out == ($past(sw[0]) ? $past(pc_tg) : $past(pc_nx)))
      else $error("unsigned lower branch wrong");
   irq_branch_a: assert property (
      acc && instr_op inside {`CABX_OP_BRANCH_IRQ_ON, `CABX_OP_BRID}
      |=> pc_out == ($past(sw[7] ^ (instr_op == `CABX_OP_BRID)) ? $past(pc_tg) : $past(pc_nx)))
      else $error("interrupt flag branch wrong");
   call_wait_a: assert property (
      acc && instr_op == `CABX_OP_REL_CALL |=> !instr_ready [*2] ##1 instr_ready)
      else $error("call not three cycles");
   ret_wait_a: assert property (
      acc && instr_op inside {`CABX_OP_RET, `CABX_OP_IRQ_EXIT} |=> !instr_ready [*3] ##1 instr_ready)
      else $error("return not four cycles");
   irq_exit_a: assert property (
      acc && instr_op == `CABX_OP_IRQ_EXIT |-> ##[1:4] sw[7])
      else $error("interrupt return left enable clear");
endmodule // cabx_exec_props

bind cabx_exec cabx_exec_props #(.PC_W(PC_W), .SP_W(SP_W)) u_props (
   .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_op(instr_op),
   .instr_bit(instr_bit), .instr_ofs(instr_ofs), .instr_next_long(instr_next_long),
   .instr_ready(instr_ready), .io_value(io_value), .pc_out(pc_out),
   .status_word_out(status_word_out));

// [verif/cabx_exec_bench.sv]
`timescale 1ns/10ps
`include "cabx_defs.vh"
module cabx_exec_bench;
   // -------
   // signals
   // -------
   reg         clk;
   reg         rst_n;
   reg         instr_valid;
   reg  [5:0]  instr_op;
   reg  [4:0]  instr_rd;
   reg  [4:0]  instr_rr;
   reg  [7:0]  instr_imm;
   reg  [2:0]  instr_bit;
   reg  [11:0] instr_ofs;
   reg         instr_next_long;
   wire        instr_ready;
   reg  [7:0]  io_value;
   reg         rf_wr_en;
   reg  [4:0]  rf_wr_addr;
   reg  [7:0]  rf_wr_data;
   reg  [4:0]  rf_rd_addr;
   wire [7:0]  rf_rd_data;
   reg         sw_wr_en;
   reg  [7:0]  sw_wr_data;
   wire [11:0] pc_out;
   wire [7:0]  status_word_out;
   reg  [11:0] exp_pc;
   reg  [11:0] ra;
   int         mismatches = 0;
   int         compares = 0;
   int         cycles = 0;

   cabx_exec #(.PC_W(12), .SP_W(3)) dut (
      .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_op(instr_op),
      .instr_rd(instr_rd), .instr_rr(instr_rr), .instr_imm(instr_imm),
      .instr_bit(instr_bit), .instr_ofs(instr_ofs), .instr_next_long(instr_next_long),
      .instr_ready(instr_ready), .io_value(io_value), .rf_wr_en(rf_wr_en),
      .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data), .rf_rd_addr(rf_rd_addr),
      .rf_rd_data(rf_rd_data), .sw_wr_en(sw_wr_en), .sw_wr_data(sw_wr_data),
      .pc_out(pc_out), .status_word_out(status_word_out));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // -------
   // tasks
   // -------
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk8(input string nm, input [7:0] e, input [7:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chkpc(input [11:0] e, input [11:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch pc expected %h seen %h", e, g);
      end
   endtask

   task automatic chkn(input int e, input int g);
      compares++;
      if (g != e) begin
         mismatches++;
         $display("mismatch cycles expected %0d seen %0d", e, g);
      end
   endtask

   // strobes drop then one idle cycle, so no strobe is set twice at one time
   task automatic wr_reg(input [4:0] a, input [7:0] d);
      rf_wr_addr = a;
      rf_wr_data = d;
      rf_wr_en = 1'b1;
      @(negedge clk);
      rf_wr_en = 1'b0;
      @(negedge clk);
   endtask

   task automatic set_sw(input [7:0] d);
      sw_wr_data = d;
      sw_wr_en = 1'b1;
      @(negedge clk);
      sw_wr_en = 1'b0;
      @(negedge clk);
   endtask

   task automatic chkreg(input [4:0] a, input [7:0] e);
      rf_rd_addr = a;
      @(negedge clk);
      chk8("reg", e, rf_rd_data);
   endtask

   task automatic exec(input [5:0] op, input [4:0] rd, input [4:0] rr, input [7:0] imm,
                       input [2:0] b, input [11:0] ofs, input nl, input [11:0] npc, input int n_e);
      int n;
      instr_op = op;
      instr_rd = rd;
      instr_rr = rr;
      instr_imm = imm;
      instr_bit = b;
      instr_ofs = ofs;
      instr_next_long = nl;
      instr_valid = 1'b1;
      @(negedge clk);
      instr_valid = 1'b0;
      n = 1;
      while (instr_ready !== 1'b1 && n < 9) begin
         @(negedge clk);
         n++;
      end
      chkpc(npc, pc_out);
      chkn(n_e, n);
      exp_pc = npc;
      @(negedge clk);
   endtask

   task automatic alu(input [5:0] op, input [4:0] rd, input [4:0] rr, input [7:0] imm,
                      input [7:0] v, input [7:0] f);
      exec(op, rd, rr, imm, 3'h0, 12'h000, 1'b0, exp_pc + 12'h001, 1);
      chk8("status", f, status_word_out);
      chkreg(rd, v);
   endtask

   task automatic br(input [5:0] op, input [7:0] s, input [2:0] b, input tk);
      set_sw(s);
      exec(op, 5'h00, 5'h00, 8'h00, b, 12'hFFB, 1'b0,
           tk ? exp_pc + 12'hFFC : exp_pc + 12'h001, tk ? 2 : 1);
      chk8("status", s, status_word_out);
   endtask

   // -------
   // scenarios
   // -------
   task automatic t_arith;
      wr_reg(5'h01, 8'h7F);
      wr_reg(5'h02, 8'h01);
      wr_reg(5'h03, 8'hFF);
      wr_reg(5'h04, 8'h00);
      wr_reg(5'h06, 8'h01);
      set_sw(8'h00);
      alu(`CABX_OP_ADD, 5'h01, 5'h02, 8'h00, 8'h80, 8'h2C);
      set_sw(8'h01);
      alu(`CABX_OP_ADDC, 5'h03, 5'h04, 8'h00, 8'h00, 8'h23);
      alu(`CABX_OP_SUB, 5'h04, 5'h06, 8'h00, 8'hFF, 8'h35);
      alu(`CABX_OP_SUBC, 5'h04, 5'h06, 8'h00, 8'hFD, 8'h14);
      alu(`CABX_OP_SUBCI, 5'h04, 5'h00, 8'h0F, 8'hEE, 8'h34);
      alu(`CABX_OP_SUB_IMM, 5'h04, 5'h00, 8'hEE, 8'h00, 8'h02);
   endtask

   task automatic t_logic;
      wr_reg(5'h07, 8'hF0);
      wr_reg(5'h08, 8'h81);
      wr_reg(5'h0A, 8'h10);
      set_sw(8'h29);
      alu(`CABX_OP_AND_IMM, 5'h07, 5'h00, 8'h3C, 8'h30, 8'h21);
      alu(`CABX_OP_OR, 5'h07, 5'h08, 8'h00, 8'hB1, 8'h35);
      alu(`CABX_OP_SETB, 5'h07, 5'h00, 8'h02, 8'hB3, 8'h35);
      alu(`CABX_OP_CLRB, 5'h07, 5'h00, 8'hB0, 8'h03, 8'h21);
      alu(`CABX_OP_TST, 5'h07, 5'h00, 8'h00, 8'h03, 8'h21);
      alu(`CABX_OP_AND, 5'h07, 5'h08, 8'h00, 8'h01, 8'h21);
      alu(`CABX_OP_ORI, 5'h07, 5'h00, 8'h80, 8'h81, 8'h35);
      set_sw(8'h00);
      alu(`CABX_OP_CPI, 5'h0A, 5'h00, 8'h20, 8'h10, 8'h15);
      alu(`CABX_OP_EOR, 5'h07, 5'h08, 8'h00, 8'h00, 8'h03);
      alu(`CABX_OP_COM, 5'h07, 5'h00, 8'h00, 8'hFF, 8'h15);
      alu(`CABX_OP_NEG, 5'h07, 5'h00, 8'h00, 8'h01, 8'h21);
      alu(`CABX_OP_INC, 5'h07, 5'h00, 8'h00, 8'h02, 8'h21);
      alu(`CABX_OP_DEC, 5'h07, 5'h00, 8'h00, 8'h01, 8'h21);
      alu(`CABX_OP_CLR, 5'h07, 5'h00, 8'h00, 8'h00, 8'h23);
      alu(`CABX_OP_SER, 5'h07, 5'h00, 8'h00, 8'hFF, 8'h23);
      alu(`CABX_OP_CP, 5'h07, 5'h08, 8'h00, 8'hFF, 8'h00);
      alu(`CABX_OP_CPC, 5'h08, 5'h07, 8'h00, 8'h81, 8'h35);
   endtask

   task automatic t_skip;
      wr_reg(5'h0B, 8'h5A);
      wr_reg(5'h0C, 8'h5A);
      wr_reg(5'h0D, 8'h5B);
      set_sw(8'hA5);
      io_value = 8'h04;
      exec(`CABX_OP_CSEQ, 5'h0B, 5'h0C, 8'h00, 3'h0, 12'h000, 1'b0, exp_pc + 12'h002, 2);
      exec(`CABX_OP_CSEQ, 5'h0B, 5'h0C, 8'h00, 3'h0, 12'h000, 1'b1, exp_pc + 12'h003, 2);
      exec(`CABX_OP_CSEQ, 5'h0B, 5'h0D, 8'h00, 3'h0, 12'h000, 1'b0, exp_pc + 12'h001, 1);
      exec(`CABX_OP_SKRC, 5'h0D, 5'h0D, 8'h00, 3'h2, 12'h000, 1'b0, exp_pc + 12'h002, 2);
      exec(`CABX_OP_SKRS, 5'h0D, 5'h0D, 8'h00, 3'h2, 12'h000, 1'b0, exp_pc + 12'h001, 1);
      exec(`CABX_OP_SKIC, 5'h00, 5'h00, 8'h00, 3'h2, 12'h000, 1'b0, exp_pc + 12'h001, 1);
      exec(`CABX_OP_SKIS, 5'h00, 5'h00, 8'h00, 3'h2, 12'h000, 1'b0, exp_pc + 12'h002, 2);
      exec(`CABX_OP_SKIC, 5'h00, 5'h00, 8'h00, 3'h0, 12'h000, 1'b1, exp_pc + 12'h003, 2);
      chk8("status", 8'hA5, status_word_out);
   endtask

   task automatic t_branch;
      br(`CABX_OP_BRFS, 8'h02, 3'h1, 1'b1);
      br(`CABX_OP_BRFC, 8'h02, 3'h1, 1'b0);
      br(`CABX_OP_BRANCH_SIGNED_GE, 8'h0C, 3'h0, 1'b1);
      br(`CABX_OP_BRANCH_SIGNED_LT, 8'h04, 3'h0, 1'b1);
      br(`CABX_OP_BRANCH_SIGNED_LT, 8'h0C, 3'h0, 1'b0);
      br(`CABX_OP_BRUGE, 8'h00, 3'h0, 1'b1);
      br(`CABX_OP_BRULO, 8'h00, 3'h0, 1'b0);
      br(`CABX_OP_BRANCH_HALF_SET, 8'h20, 3'h0, 1'b1);
      br(`CABX_OP_BRANCH_HALF_CLR, 8'h20, 3'h0, 1'b0);
      br(`CABX_OP_BRANCH_TBIT_SET, 8'h40, 3'h0, 1'b1);
      br(`CABX_OP_BRANCH_TBIT_CLR, 8'h00, 3'h0, 1'b1);
      br(`CABX_OP_BRANCH_OVF_SET, 8'h00, 3'h0, 1'b0);
      br(`CABX_OP_BRANCH_OVF_CLR, 8'h00, 3'h0, 1'b1);
      br(`CABX_OP_BRANCH_IRQ_ON, 8'h80, 3'h0, 1'b1);
      br(`CABX_OP_BRID, 8'h80, 3'h0, 1'b0);
   endtask

   task automatic t_jump;
      exec(`CABX_OP_REL_JUMP, 5'h00, 5'h00, 8'h00, 3'h0, 12'h020, 1'b0, exp_pc + 12'h021, 2);
      ra = exp_pc + 12'h001;
      exec(`CABX_OP_REL_CALL, 5'h00, 5'h00, 8'h00, 3'h0, 12'h040, 1'b0, exp_pc + 12'h041, 3);
      exec(`CABX_OP_RET, 5'h00, 5'h00, 8'h00, 3'h0, 12'h000, 1'b0, ra, 4);
      set_sw(8'h00);
      ra = exp_pc + 12'h001;
      exec(`CABX_OP_REL_CALL, 5'h00, 5'h00, 8'h00, 3'h0, 12'hF00, 1'b0, exp_pc + 12'hF01, 3);
      exec(`CABX_OP_IRQ_EXIT, 5'h00, 5'h00, 8'h00, 3'h0, 12'h000, 1'b0, ra, 4);
      chk8("status", 8'h80, status_word_out);
   endtask

   // -------
   // main
   // -------
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         give_verdict;
      end
   end

   initial begin
      {rst_n, instr_valid, instr_next_long, rf_wr_en, sw_wr_en} = 5'h00;
      {instr_op, instr_rd, instr_rr, instr_imm, instr_bit} = 27'h000_0000;
      {instr_ofs, io_value, rf_wr_addr, rf_wr_data, rf_rd_addr, sw_wr_data} = 46'h0;
      exp_pc = 12'h000;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      t_arith;
      t_logic;
      t_skip;
      t_branch;
      t_jump;
      give_verdict;
   end
endmodule // cabx_exec_bench
